// [design/sadc_seq.sv]
// Successive-approximation converter sequencer with register port.
//
// Operation
// RQ1 - Software setting start bit 3 begins conversion, regardless of external enable.
// RQ2 - With external enable bit 5 set, a start-pin rising edge starts conversion.
// RQ3 - Trigger source holds a symmetric start pulse of at least two cycles.
// RQ4 - Start-pin edge seen at cycle end; conversion begins next cycle.
// RQ5 - Software start begins in the cycle after the setting write.
// RQ6 - Start bit has a command element for writes, busy element for reads.
// RQ7 - Two initiation cycles; busy set after the first; sampling after second.
// RQ8 - Selected analog input is sampled for eight cycles before approximation.
// RQ9 - Approximation starts with MSB only set; kept if input exceeds DAC.
// RQ10 - Each lower bit is tried in turn until all ten bits resolve.
// RQ11 - Each bit decision takes four cycles.
// RQ12 - Upper eight bits to result register, low two to control bits 7,6.
// RQ13 - Done flag set, busy cleared, 52 cycles after start.
// RQ14 - Control bits 1:0 and second control bit 2 select one of eight channels.
// RQ15 - Start requests during a running conversion are ignored.
// RQ16 - Completed result kept while done flag is one, also through idle.
// RQ17 - Entering idle or power-down aborts a conversion in progress.
// RQ18 - Result is an unsigned ten-bit code, all ones at full reference.
// RQ19 - Done flag sticky until software clears it; interrupts when enabled.
//
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "sadc_params.svh"

module sadc_seq #(
   parameter int RES_BITS = 10,
   parameter int CLK_MHZ  = 50
) (
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                arst_n,
   // Register port
   input  wire logic [3:0]          reg_addr,
   input  wire logic [7:0]          reg_wdata,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   output logic      [7:0]          reg_rdata,
   // External trigger
   input  wire logic                ext_start_pin,
   // Analog front end
   output logic      [2:0]          chan_sel,
   output logic      [RES_BITS-1:0] dac_code,
   output logic                     sample_en,
   input  wire logic                cmp_above,
   // Interrupt
   output logic                     irq
);

   // ------------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------------
   // The register map packs the code as eight plus two bits, so another
   // width would need a new map, not only a wider datapath.
   initial begin
      if (RES_BITS != 10) $error("sadc_seq serves ten-bit results only");
      if (CLK_MHZ < 1) $error("sadc_seq needs a clock of at least 1 MHz");
      if (`SADC_INIT_CYC + `SADC_SAMPLE_CYC + RES_BITS * `SADC_BIT_CYC !=
          `SADC_TOTAL_CYC - 2) $error("sadc_seq phase counts do not add up");
   end

   // ------------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------------
   logic rst_s1_r;
   logic rst_n_r;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_s1_r <= 1'b0;
         rst_n_r  <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n_r  <= rst_s1_r;
      end
   end

   // ------------------------------------------------------------------
   // State and storage
   // ------------------------------------------------------------------
   sadc_pkg::sadc_state_e state_r;
   // Six bits cover the longest single phase.
   logic [5:0]            cnt_r;
   logic [3:0]            bit_idx_r;
   logic [RES_BITS-1:0]   sar_r;
   logic [RES_BITS-1:0]   result_r;
   logic                  start_cmd_r;
   logic                  busy_r;
   logic                  done_r;
   logic                  ext_en_r;
   logic [2:0]            chan_r;
   logic                  irq_en_r;
   logic                  idle_mode_r;
   logic                  pdown_mode_r;
   logic                  ext_prev_r;

   logic wr_ctrl;
   logic wr_ctrl2;
   logic wr_clr;
   logic wr_pwr;
   logic wr_irq_en;
   logic busy_set;
   logic ext_edge;
   logic start_req;
   logic abort;
   logic finish;
   logic low_power_entry;

   // ------------------------------------------------------------------
   // Register decode
   // ------------------------------------------------------------------
   assign wr_ctrl  = reg_wr && (reg_addr == `SADC_OFF_CTRL);
   assign wr_ctrl2 = reg_wr && (reg_addr == `SADC_OFF_CTRL2);
   assign wr_clr   = reg_wr && (reg_addr == `SADC_OFF_IRQ_CLR);
   assign wr_pwr   = reg_wr && (reg_addr == `SADC_OFF_PWR);
   assign wr_irq_en = reg_wr && (reg_addr == `SADC_OFF_IRQ_EN);

   // Edge is judged on the previous cycle level, so a pulse shorter than
   // one cycle may be missed; the trigger source must stretch it.
   assign ext_edge = ext_en_r && ext_start_pin && !ext_prev_r; // RQ2 RQ3 RQ4

   assign low_power_entry = wr_pwr && (reg_wdata[`SADC_BIT_IDLE] ||
                                       reg_wdata[`SADC_BIT_PDOWN]);
   // Power-mode writes abort only a running conversion; while idle they
   // merely block new starts.
   assign abort  = low_power_entry && (state_r != sadc_pkg::SADC_IDLE); // RQ17
   // The last bit decision ends the conversion.
   assign finish = (state_r == sadc_pkg::SADC_APPROX) &&
                   (cnt_r == 6'(`SADC_BIT_CYC - 1)) && (bit_idx_r == 4'h0);
   // A start only counts from idle; busy conversions ignore it.
   assign start_req = (start_cmd_r || ext_edge) &&
                      (state_r == sadc_pkg::SADC_IDLE) &&
                      !idle_mode_r && !pdown_mode_r; // RQ15
   // Busy rises at the end of the first initiation cycle.
   assign busy_set = (state_r == sadc_pkg::SADC_INIT) && (cnt_r == 6'h00);

   // ------------------------------------------------------------------
   // Command element and configuration
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         start_cmd_r <= 1'b0;
      end else if (start_req) begin
         start_cmd_r <= 1'b0;
      end else if (wr_ctrl && reg_wdata[`SADC_BIT_START] &&
                   (state_r == sadc_pkg::SADC_IDLE)) begin
         // A write landing during a conversion must not leave a start
         // behind that would fire once the sequencer is idle again.
         start_cmd_r <= 1'b1; // RQ1 RQ5 RQ6 RQ15
      end else if (state_r != sadc_pkg::SADC_IDLE) begin
         start_cmd_r <= 1'b0; // RQ15
      end
   end

   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         ext_en_r <= 1'b0;
      end else if (wr_ctrl) begin
         ext_en_r <= reg_wdata[`SADC_BIT_EXT_EN]; // RQ2
      end
   end

   // The channel bits live in two registers; each write moves its own.
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         chan_r <= 3'h0;
      end else begin
         if (wr_ctrl) begin
            chan_r[0] <= reg_wdata[`SADC_BIT_CH0]; // RQ14
            chan_r[1] <= reg_wdata[`SADC_BIT_CH1]; // RQ14
         end
         if (wr_ctrl2) begin
            chan_r[2] <= reg_wdata[`SADC_BIT_CH2]; // RQ14
         end
      end
   end

   // Power mode bits; either one set aborts and blocks new starts.
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         idle_mode_r  <= 1'b0;
         pdown_mode_r <= 1'b0;
      end else if (wr_pwr) begin
         idle_mode_r  <= reg_wdata[`SADC_BIT_IDLE]; // RQ17
         pdown_mode_r <= reg_wdata[`SADC_BIT_PDOWN]; // RQ17
      end
   end

   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         irq_en_r <= 1'b0;
      end else if (wr_irq_en) begin
         irq_en_r <= reg_wdata[0]; // RQ19
      end
   end

   // Start pin history for the edge detector; it resets to the pin's
   // idle low level so no false edge follows reset.
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         ext_prev_r <= 1'b0;
      end else begin
         ext_prev_r <= ext_start_pin; // RQ4
      end
   end

   // ------------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         state_r   <= sadc_pkg::SADC_IDLE;
         cnt_r     <= 6'h00;
         bit_idx_r <= 4'h0;
         sar_r     <= '0;
      end else if (abort) begin
         state_r <= sadc_pkg::SADC_IDLE; // RQ17
         cnt_r   <= 6'h00;
      end else begin
         unique case (state_r)
            sadc_pkg::SADC_IDLE: begin
               if (start_req) begin
                  state_r <= sadc_pkg::SADC_INIT; // RQ4 RQ5
                  cnt_r   <= 6'h00;
               end
            end
            sadc_pkg::SADC_INIT: begin
               if (cnt_r == 6'(`SADC_INIT_CYC - 1)) begin
                  state_r <= sadc_pkg::SADC_SAMPLE; // RQ7
                  cnt_r   <= 6'h00;
               end else begin
                  cnt_r <= cnt_r + 6'h01;
               end
            end
            sadc_pkg::SADC_SAMPLE: begin
               if (cnt_r == 6'(`SADC_SAMPLE_CYC - 1)) begin
                  state_r   <= sadc_pkg::SADC_APPROX; // RQ8
                  cnt_r     <= 6'h00;
                  bit_idx_r <= 4'(RES_BITS - 1);
                  sar_r     <= {1'b1, {(RES_BITS-1){1'b0}}}; // RQ9
               end else begin
                  cnt_r <= cnt_r + 6'h01;
               end
            end
            sadc_pkg::SADC_APPROX: begin
               if (cnt_r == 6'(`SADC_BIT_CYC - 1)) begin // RQ11
                  cnt_r <= 6'h00;
                  if (!cmp_above) begin
                     sar_r[bit_idx_r] <= 1'b0; // RQ9 RQ10
                  end
                  if (bit_idx_r == 4'h0) begin
                     state_r <= sadc_pkg::SADC_IDLE;
                  end else begin
                     bit_idx_r <= bit_idx_r - 4'h1;
                     sar_r[bit_idx_r - 4'h1] <= 1'b1; // RQ10
                  end
               end else begin
                  cnt_r <= cnt_r + 6'h01;
               end
            end
            default: state_r <= sadc_pkg::SADC_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Busy status element, done flag and result
   // ------------------------------------------------------------------
   // The final bit decision is folded in here so the stored result is
   // exact in the very cycle the done flag rises.
   logic [RES_BITS-1:0] final_code;
   always_comb begin
      final_code    = sar_r;
      final_code[0] = cmp_above;
   end

   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         busy_r <= 1'b0;
      end else if (abort || finish) begin
         busy_r <= 1'b0; // RQ13 RQ17
      end else if (busy_set) begin
         busy_r <= 1'b1; // RQ6 RQ7
      end
   end

   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         done_r <= 1'b0;
      end else if (finish && !abort) begin
         done_r <= 1'b1; // RQ13 RQ19
      end else if ((wr_clr && reg_wdata[0]) ||
                   (wr_ctrl && !reg_wdata[`SADC_BIT_DONE])) begin
         done_r <= 1'b0; // RQ19
      end
   end

   // Result is only overwritten by a finished conversion; idle entry and
   // aborts never touch it.
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         result_r <= '0;
      end else if (finish && !abort && !done_r) begin
         result_r <= final_code; // RQ12 RQ16 RQ18
      end
   end

   // ------------------------------------------------------------------
   // Outputs and read port
   // ------------------------------------------------------------------
   // The DAC follows the trial word directly, so the comparator has a
   // full bit time to settle before its decision is taken.
   assign chan_sel  = chan_r; // RQ14
   assign dac_code  = sar_r;
   assign sample_en = (state_r == sadc_pkg::SADC_SAMPLE);
   assign irq       = done_r && irq_en_r; // RQ19

   // Read data fall back to zero outside the answer cycle, so a late
   // sample never shows a stale register.
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         reg_rdata <= `SADC_RST_BYTE;
      end else if (reg_rd) begin
         unique case (reg_addr)
            `SADC_OFF_CTRL: reg_rdata <= {result_r[1], result_r[0], // RQ12
                                          ext_en_r, done_r, busy_r, // RQ6
                                          1'b0, chan_r[1:0]};
            `SADC_OFF_RESH:     reg_rdata <= result_r[9:2]; // RQ12
            `SADC_OFF_CTRL2:    reg_rdata <= {5'h00, chan_r[2], 2'h0};
            `SADC_OFF_IRQ_STAT: reg_rdata <= {7'h00, done_r};
            `SADC_OFF_IRQ_EN:   reg_rdata <= {7'h00, irq_en_r};
            `SADC_OFF_PWR:      reg_rdata <= {6'h00, pdown_mode_r,
                                              idle_mode_r};
            default:            reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

endmodule : sadc_seq

// [design/sadc_params.svh]
// Register offsets, field positions, reset values and timing counts.
`ifndef SADC_PARAMS_SVH
`define SADC_PARAMS_SVH
`define SADC_OFF_CTRL       4'h0
`define SADC_OFF_RESH       4'h1
`define SADC_OFF_CTRL2      4'h2
`define SADC_OFF_IRQ_STAT   4'h3
`define SADC_OFF_IRQ_EN     4'h4
`define SADC_OFF_IRQ_CLR    4'h5
`define SADC_OFF_PWR        4'h6
`define SADC_BIT_CH0        0
`define SADC_BIT_CH1        1
`define SADC_BIT_START      3
`define SADC_BIT_DONE       4
`define SADC_BIT_EXT_EN     5
`define SADC_BIT_RES0       6
`define SADC_BIT_RES1       7
`define SADC_BIT_CH2        2
`define SADC_BIT_IDLE       0
`define SADC_BIT_PDOWN      1
`define SADC_RST_BYTE       8'h00
`define SADC_INIT_CYC       2
`define SADC_SAMPLE_CYC     8
`define SADC_BIT_CYC        4
`define SADC_TOTAL_CYC      52
`endif

// [design/sadc_pkg.sv]
// Types shared by the converter sequencer.
package sadc_pkg;
   typedef enum logic [2:0] {
      SADC_IDLE,
      SADC_INIT,
      SADC_SAMPLE,
      SADC_APPROX
   } sadc_state_e;
endpackage : sadc_pkg

// [test/sadc_analog_model.sv]
// Analog inputs and external trigger source for the converter.
`timescale 1ns/1ps
module sadc_analog_model (
   // Clock
   input  wire logic             clk,
   // Converter side
   input  wire logic [2:0]       chan_sel,
   input  wire logic [9:0]       dac_code,
   output logic                  cmp_above,
   output logic                  ext_start_pin,
   // Bench control
   input  wire logic [7:0][9:0]  vin_tab,
   input  wire logic             fire
);
   // Inclusive compare (input >= DAC), so a full-scale input resolves to all ones.
   assign cmp_above = vin_tab[chan_sel] >= dac_code;
   initial ext_start_pin = 1'b0;
   always @(posedge fire) begin
      repeat (3) @(posedge clk);
      ext_start_pin <= 1'b1;
      repeat (3) @(posedge clk);
      ext_start_pin <= 1'b0;
   end
endmodule : sadc_analog_model

// [test/sadc_seq_monitor.sv]
// Port-level assertions for the converter sequencer.
`timescale 1ns/1ps
module sadc_seq_monitor #(
   parameter int RES_BITS = 10
) (
   input wire logic                clk,
   input wire logic                arst_n,
   input wire logic [3:0]          reg_addr,
   input wire logic [7:0]          reg_wdata,
   input wire logic                reg_wr,
   input wire logic                reg_rd,
   input wire logic [7:0]          reg_rdata,
   input wire logic [RES_BITS-1:0] dac_code,
   input wire logic                sample_en,
   input wire logic                cmp_above,
   input wire logic                irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   property p_rd_idle;
      !$past(reg_rd) |-> reg_rdata == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
   property p_samp;
      $rose(sample_en) |-> sample_en[*8] ##1 !sample_en;
   endproperty
   a_samp: assert property (p_samp) else $error("sample length");
   property p_msb;
      $fell(sample_en) |-> ##[0:1] dac_code == 10'h200;
   endproperty
   a_msb: assert property (p_msb) else $error("first trial");
   sequence s_msb;
      $changed(dac_code) && dac_code == 10'h200;
   endsequence
   property p_keep;
      s_msb ##3 cmp_above |=> dac_code == 10'h300;
   endproperty
   a_keep: assert property (p_keep) else $error("msb kept");
   property p_clr;
      s_msb ##3 !cmp_above |=> dac_code == 10'h100;
   endproperty
   a_clr: assert property (p_clr) else $error("msb cleared");
   property p_hold;
      $changed(dac_code) && dac_code[1:0] == 2'b00 && dac_code != 10'h000
         |=> ($stable(dac_code) || dac_code == 10'h000)[*3];
   endproperty
   a_hold: assert property (p_hold) else $error("bit time");
   property p_irq_clr;
      reg_wr && reg_addr == 4'h5 && reg_wdata[0] |-> ##[1:2] !irq;
   endproperty
   a_irq_clr: assert property (p_irq_clr) else $error("irq clear");
   property p_irq_mask;
      reg_wr && reg_addr == 4'h4 && !reg_wdata[0] |-> ##[1:2] !irq;
   endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("irq mask");
   c_samp: cover property ($rose(sample_en));
   c_full: cover property (dac_code == 10'h3ff);
   c_irq: cover property ($rose(irq));
endmodule : sadc_seq_monitor
bind sadc_seq sadc_seq_monitor #(.RES_BITS(RES_BITS)) u_sadc_seq_monitor (.*);

// [test/sar_adc_sequencer_tb_top.sv]
// Self-checking bench for the converter sequencer.
`timescale 1ns/1ps
module sar_adc_sequencer_tb_top;
   logic            clk, arst_n, reg_wr, reg_rd, fire, sample_en;
   logic            cmp_above, irq, ext_start_pin;
   logic [3:0]      reg_addr;
   logic [7:0]      reg_wdata, reg_rdata, v;
   logic [2:0]      chan_sel;
   logic [9:0]      dac_code;
   logic [7:0][9:0] vin_tab;
   int              mismatches, n_tests, el;
   time             t0;
   sadc_seq u_sadc_seq (.*);
   sadc_analog_model u_sadc_analog_model (.*);
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic end_of_test();
      $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a);
      @(posedge clk);
      {reg_addr, reg_rd} <= {a, 1'b1};
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask : rd
   task automatic wait_done(input int lo, input int hi);
      int n;
      n = 0;
      v = 8'h00;
      while (v[4] !== 1'b1 && n < 60) begin
         rd(4'h0);
         n++;
      end
      if (v[4] !== 1'b1) begin
         mismatches++;
         end_of_test();
      end
      el = int'(($time - 1 - t0) / 20);
      chk(el >= lo && el <= hi, 1);
   endtask : wait_done
   task automatic t_conv(input logic [2:0] ch);
      wr(4'h5, 8'h01);
      wr(4'h2, {5'h00, ch[2], 2'b00});
      wr(4'h0, {6'h02, ch[1:0]});
      t0 = $time;
      repeat (2) @(posedge clk);
      rd(4'h0);
      chk(v[3], 1);
      wait_done(50, 55);
      chk({v[3], v[7:6]}, {1'b0, vin_tab[ch][1:0]});
      rd(4'h1);
      chk(v, vin_tab[ch][9:2]);
      chk(irq, 1);
   endtask : t_conv
   task automatic t_ignore();
      wr(4'h2, 8'h00);
      wr(4'h0, 8'h28);
      t0 = $time;
      fire <= 1'b1;
      repeat (20) @(posedge clk);
      wr(4'h0, 8'h28);
      fire <= 1'b0;
      wait_done(50, 55);
      rd(4'h1);
      chk(v, vin_tab[0][9:2]);
      rd(4'h0);
      chk(v[3], 0);
   endtask : t_ignore
   task automatic t_ext();
      wr(4'h0, 8'h22);
      fire <= 1'b1;
      for (int i = 0; i < 8 && ext_start_pin !== 1'b1; i++) @(posedge clk);
      if (ext_start_pin !== 1'b1) begin
         mismatches++;
         end_of_test();
      end
      t0 = $time;
      fire <= 1'b0;
      wait_done(49, 56);
      rd(4'h1);
      chk(v, vin_tab[2][9:2]);
      wr(4'h0, 8'h02);
      fire <= 1'b1;
      repeat (70) @(posedge clk);
      fire <= 1'b0;
      rd(4'h0);
      chk(v[4:3], 0);
   endtask : t_ext
   task automatic t_keep_abort();
      t_conv(3'h3);
      wr(4'h2, 8'h04);
      wr(4'h0, 8'h18);
      repeat (70) @(posedge clk);
      wr(4'h6, 8'h01);
      rd(4'h1);
      chk(v, vin_tab[3][9:2]);
      wr(4'h6, 8'h00);
      wr(4'h0, 8'h08);
      repeat (30) @(posedge clk);
      wr(4'h6, 8'h02);
      wr(4'h6, 8'h00);
      repeat (40) @(posedge clk);
      rd(4'h0);
      chk(v[4:3], 0);
   endtask : t_keep_abort
   task automatic t_irq();
      t_conv(3'h5);
      wr(4'h4, 8'h00);
      rd(4'h3);
      chk({irq, v[0]}, 1);
      wr(4'h4, 8'h01);
      rd(4'hf);
      chk({irq, v}, 10'h100);
      wr(4'h5, 8'h01);
      rd(4'h3);
      chk({irq, v[0]}, 0);
   endtask : t_irq
   initial begin
      {reg_wr, reg_rd, fire, arst_n, reg_addr, reg_wdata} = '0;
      vin_tab = {10'h3fe, 10'h001, 10'h1ff, 10'h2ab,
                 10'h155, 10'h2aa, 10'h000, 10'h3ff};
      mismatches = 0;
      n_tests = 0;
      repeat (10) @(posedge clk);
      arst_n <= 1'b1;
      repeat (5) @(posedge clk);
      wr(4'h4, 8'h01);
      for (int c = 0; c < 8; c++) t_conv(3'(c));
      t_ignore();
      t_ext();
      t_keep_abort();
      t_irq();
      end_of_test();
   end
endmodule : sar_adc_sequencer_tb_top
